// ---- cpu_bus_model.sv ----
module cpu_bus_model (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [timer_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    // idle lines flip so a stale value cannot pass for a held one
    paddr <= ~a;
    pwdata <= {24'h0, ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic power_up;
    wr(OFS_POWER, 8'h00);
  endtask
  // temp byte is shared: no other access may fall between the halves
  task automatic wr16(input logic [7:0] hiAddr, input logic [15:0] v);
    wr(hiAddr, v[15:8]);
    wr(hiAddr - 8'h04, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] loAddr, output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    rd(loAddr, l);
    rd(loAddr + 8'h04, h);
    v = {h, l};
  endtask
endmodule

// ---- sixteen_bit_timer_core.sv ----
// Behaviour
// - count clock from prescaler or external pin
// - no clock selected: counter frozen
// - select zero stops; counter still CPU-accessible
// - CPU counter write beats count/clear
// - 16-bit count/compare/capture, 8-bit controls
// - BOTTOM is 0x0000
// - MAX is 0xFFFF
// - TOP fixed, compare A, or capture
// - compare A as TOP: no PWM on A
// - compare A TOP is double buffered in PWM modes only
// - compare values always checked, drive outputs
// - compare match sets unit's match flag
// - four flags, one register, individually masked
// - edge stores counter; pin or comparator source
// - optional noise filter on capture input
// - capture flag with copy; ack or write-one clears
// - four-bit wave mode split; force bits in C
// - one shared temporary high-byte register
// - low-byte write loads temp plus low
// - low-byte read copies high into temp
// - compare reads bypass temporary register
module sixteen_bit_timer_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extCountPin,
  input wire logic capturePin,
  input wire logic comparatorOut,
  input wire logic ackOverflow,
  input wire logic ackCompareA,
  input wire logic ackCompareB,
  input wire logic ackCapture,
  output logic irqOverflow,
  output logic irqCompareA,
  output logic irqCompareB,
  output logic irqCapture,
  output logic compareOutA,
  output logic compareOutAEn,
  output logic compareOutB,
  output logic compareOutBEn
);
  import timer_pkg::*;

  logic [7:0] ctrlA_r, ctrlA_nxt, ctrlB_r, ctrlB_nxt;
  logic capSrc_r, capSrc_nxt;
  logic [3:0] mask_r, mask_nxt, flags_r, flags_nxt;
  logic timerPowerOff_r, timerPowerOff_nxt;
  logic [7:0] temp_r, temp_nxt, snap_r, snap_nxt, rd_r, rd_nxt;
  logic [15:0] cnt_r, cnt_nxt, cap_r, cap_nxt;
  logic dirDown_r, dirDown_nxt;
  logic [9:0] presc_r, presc_nxt;
  logic extPrev_r;
  logic [FILTER_LEN-1:0] samp_r, samp_nxt;
  logic capLevel_r, capLevel_nxt;

  logic wrEn, rdSetup, mapped;
  logic [3:0] waveMode;
  logic [2:0] clockSel;
  logic tick, atTop, atBottom, atMax, cntWr, capWr, capEv, capSrcLvl, ovfSet, updEv;
  logic [15:0] topVal;
  logic isPwm, isFast, isDual, isPfc, topOcra, topIcr;
  logic [1:0] comMode [N_UNITS];
  logic [N_UNITS-1:0] forceEv, matchEv;
  logic [15:0] cmpBuf [N_UNITS];
  logic [15:0] cmpAct [N_UNITS];
  logic [N_UNITS-1:0] outPin, outEn;

  // zero-wait slave; read data is latched in the setup cycle
  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = {24'h000000, rd_r};

  assign waveMode = {ctrlB_r[WAVE_HI_LSB +: 2], ctrlA_r[WAVE_LO_LSB +: 2]};
  assign clockSel = ctrlB_r[CS_LSB +: 3];
  assign comMode[0] = ctrlA_r[COM_A_LSB +: 2];
  assign comMode[1] = ctrlA_r[COM_B_LSB +: 2];
  assign forceEv[0] = wrEn && paddr == OFS_CTRL_C && pwdata[FORCE_A_BIT] && !isPwm;
  assign forceEv[1] = wrEn && paddr == OFS_CTRL_C && pwdata[FORCE_B_BIT] && !isPwm;

  assign cntWr = wrEn && paddr == OFS_CNT_LO;
  assign capWr = wrEn && paddr == OFS_CAP_LO;
  assign atBottom = cnt_r == BOTTOM;
  assign atMax = cnt_r == MAX;
  assign atTop = cnt_r == topVal;

  // wave mode decode: TOP source and slope
  always_comb begin
    topVal = MAX;
    isFast = 1'b0;
    isDual = 1'b0;
    isPfc = 1'b0;
    topOcra = 1'b0;
    topIcr = 1'b0;
    unique case (waveMode)
      4'h0, 4'hd: topVal = MAX;
      4'h1: begin topVal = TOP_8BIT; isDual = 1'b1; end
      4'h2: begin topVal = TOP_9BIT; isDual = 1'b1; end
      4'h3: begin topVal = TOP_10BIT; isDual = 1'b1; end
      4'h4: begin topVal = cmpAct[0]; topOcra = 1'b1; end
      4'h5: begin topVal = TOP_8BIT; isFast = 1'b1; end
      4'h6: begin topVal = TOP_9BIT; isFast = 1'b1; end
      4'h7: begin topVal = TOP_10BIT; isFast = 1'b1; end
      4'h8: begin topVal = cap_r; topIcr = 1'b1; isDual = 1'b1; isPfc = 1'b1; end
      4'h9: begin topVal = cmpAct[0]; topOcra = 1'b1; isDual = 1'b1; isPfc = 1'b1; end
      4'ha: begin topVal = cap_r; topIcr = 1'b1; isDual = 1'b1; end
      4'hb: begin topVal = cmpAct[0]; topOcra = 1'b1; isDual = 1'b1; end
      4'hc: begin topVal = cap_r; topIcr = 1'b1; end
      4'he: begin topVal = cap_r; topIcr = 1'b1; isFast = 1'b1; end
      4'hf: begin topVal = cmpAct[0]; topOcra = 1'b1; isFast = 1'b1; end
    endcase
    isPwm = isFast || isDual;
  end

  // timer clock enable; power-off and code zero hold it low
  always_comb begin
    presc_nxt = presc_r + 10'h001;
    unique case (clockSel)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (presc_r & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64: tick = (presc_r & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256: tick = (presc_r & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024: tick = (presc_r & PRE_MASK_1024) == PRE_MASK_1024;
      CS_EXT_FALL: tick = extPrev_r && !extCountPin;
      CS_EXT_RISE: tick = !extPrev_r && extCountPin;
    endcase
    if (timerPowerOff_r) begin
      tick = 1'b0;
    end
  end

  // counter: bidirectional in dual-slope modes
  always_comb begin
    cnt_nxt = cnt_r;
    dirDown_nxt = dirDown_r;
    if (cntWr) begin
      cnt_nxt = {temp_r, pwdata[7:0]};
    end else if (tick) begin
      if (isDual) begin
        if (!dirDown_r) begin
          if (cnt_r >= topVal && !atBottom) begin
            dirDown_nxt = 1'b1;
            cnt_nxt = cnt_r - 16'h0001;
          end else if (!atTop) begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end else if (atBottom) begin
          dirDown_nxt = 1'b0;
          cnt_nxt = cnt_r + 16'h0001;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end else begin
        // past a lowered TOP the count runs on to MAX and wraps
        cnt_nxt = atTop ? BOTTOM : cnt_r + 16'h0001;
        dirDown_nxt = 1'b0;
      end
    end
  end

  always_comb begin
    if (isFast) begin
      ovfSet = tick && atTop;
    end else if (isDual) begin
      ovfSet = tick && atBottom && dirDown_r;
    end else begin
      ovfSet = tick && atMax;
    end
    // new compare values take effect at TOP, or BOTTOM in the PFC modes
    updEv = tick && (isPfc ? (atBottom && dirDown_r) : atTop);
  end

  // compare units
  for (genvar i = 0; i < N_UNITS; i++) begin : gUnit
    localparam logic [7:0] LO_OFS = (i == 0) ? OFS_CMPA_LO : OFS_CMPB_LO;
    logic [15:0] buf_r, buf_nxt, act_r, act_nxt;
    logic out_r, out_nxt, lockPwm, invert;

    assign lockPwm = (i == 0) && topOcra && isPwm;
    assign invert = comMode[i] == 2'h3;
    assign matchEv[i] = tick && !cntWr && cnt_r == act_r;
    assign cmpBuf[i] = buf_r;
    assign cmpAct[i] = act_r;
    assign outPin[i] = out_r;
    // in PWM modes a toggle setting leaves the pin undriven; A with compare A as TOP drives it only when set to toggle
    assign outEn[i] = comMode[i] != 2'h0 && !(isPwm && (lockPwm ? comMode[i] != 2'h1 : comMode[i] == 2'h1));

    always_comb begin
      buf_nxt = buf_r;
      act_nxt = act_r;
      out_nxt = out_r;
      if (wrEn && paddr == LO_OFS) begin
        buf_nxt = {temp_r, pwdata[7:0]};
        if (!isPwm) begin
          act_nxt = buf_nxt;
        end
      end else if (isPwm && updEv) begin
        act_nxt = buf_r;
      end
      if (!isPwm) begin
        if (matchEv[i] || forceEv[i]) begin
          unique case (comMode[i])
            2'h0: out_nxt = out_r;
            2'h1: out_nxt = !out_r;
            2'h2: out_nxt = 1'b0;
            2'h3: out_nxt = 1'b1;
          endcase
        end
      end else if (comMode[i] == 2'h1) begin
        if (lockPwm && matchEv[i]) begin
          out_nxt = !out_r;
        end
      end else if (comMode[i] != 2'h0 && !lockPwm) begin
        if (isFast) begin
          if (tick && atTop) begin
            out_nxt = !invert;
          end else if (matchEv[i]) begin
            out_nxt = invert;
          end
        end else if (matchEv[i]) begin
          out_nxt = dirDown_r ? !invert : invert;
        end
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        buf_r <= WORD_RST;
        act_r <= WORD_RST;
        out_r <= 1'b0;
      end else begin
        buf_r <= buf_nxt;
        act_r <= act_nxt;
        out_r <= out_nxt;
      end
    end
  end

  assign compareOutA = outPin[0];
  assign compareOutB = outPin[1];
  assign compareOutAEn = outEn[0];
  assign compareOutBEn = outEn[1];

  // capture path
  always_comb begin
    capSrcLvl = capSrc_r ? comparatorOut : capturePin;
    samp_nxt = {samp_r[FILTER_LEN-2:0], capSrcLvl};
    capLevel_nxt = capSrcLvl;
    if (ctrlB_r[FILTER_EN_BIT]) begin
      // costs FILTER_LEN cycles of latency on every edge
      if (&samp_r) begin
        capLevel_nxt = 1'b1;
      end else if (~|samp_r) begin
        capLevel_nxt = 1'b0;
      end else begin
        capLevel_nxt = capLevel_r;
      end
    end
    // in ICR-as-TOP modes the capture register is not overwritten
    capEv = capLevel_nxt != capLevel_r && capLevel_nxt == ctrlB_r[CAP_EDGE_BIT] && !topIcr && !timerPowerOff_r;
    cap_nxt = cap_r;
    if (capWr) begin
      cap_nxt = {temp_r, pwdata[7:0]};
    end else if (capEv) begin
      cap_nxt = cnt_r;
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_comb begin
    logic [3:0] setV;
    logic [3:0] clrV;
    setV = 4'h0;
    clrV = 4'h0;
    setV[FLAG_OVF] = ovfSet;
    setV[FLAG_CMPA] = matchEv[0];
    setV[FLAG_CMPB] = matchEv[1];
    setV[FLAG_CAP] = (capEv && !capWr) || (topIcr && tick && atTop);
    if (wrEn && paddr == OFS_FLAGS) begin
      clrV = pwdata[3:0];
    end
    clrV[FLAG_OVF] = clrV[FLAG_OVF] | ackOverflow;
    clrV[FLAG_CMPA] = clrV[FLAG_CMPA] | ackCompareA;
    clrV[FLAG_CMPB] = clrV[FLAG_CMPB] | ackCompareB;
    clrV[FLAG_CAP] = clrV[FLAG_CAP] | ackCapture;
    flags_nxt = (flags_r & ~clrV) | setV;
  end

  assign irqOverflow = flags_r[FLAG_OVF] && mask_r[FLAG_OVF];
  assign irqCompareA = flags_r[FLAG_CMPA] && mask_r[FLAG_CMPA];
  assign irqCompareB = flags_r[FLAG_CMPB] && mask_r[FLAG_CMPB];
  assign irqCapture = flags_r[FLAG_CAP] && mask_r[FLAG_CAP];

  // register file, temporary byte and read path
  always_comb begin
    ctrlA_nxt = ctrlA_r;
    ctrlB_nxt = ctrlB_r;
    capSrc_nxt = capSrc_r;
    mask_nxt = mask_r;
    timerPowerOff_nxt = timerPowerOff_r;
    temp_nxt = temp_r;
    snap_nxt = snap_r;
    rd_nxt = rd_r;
    mapped = 1'b1;
    unique case (paddr)
      OFS_CTRL_A, OFS_CTRL_B, OFS_CTRL_C, OFS_CNT_LO, OFS_CNT_HI, OFS_CMPA_LO, OFS_CMPA_HI,
      OFS_CMPB_LO, OFS_CMPB_HI, OFS_CAP_LO, OFS_CAP_HI, OFS_FLAGS, OFS_MASK, OFS_POWER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    if (wrEn) begin
      unique case (paddr)
        OFS_CTRL_A: ctrlA_nxt = pwdata[7:0];
        OFS_CTRL_B: ctrlB_nxt = pwdata[7:0];
        OFS_CTRL_C: capSrc_nxt = pwdata[CAP_SRC_BIT];
        OFS_MASK: mask_nxt = pwdata[3:0];
        OFS_POWER: timerPowerOff_nxt = pwdata[POWER_BIT];
        OFS_CNT_HI, OFS_CMPA_HI, OFS_CMPB_HI, OFS_CAP_HI: temp_nxt = pwdata[7:0];
        default: temp_nxt = temp_r;
      endcase
    end
    // high byte is snapped with the low byte so both halves match
    if (psel && penable && !pwrite && (paddr == OFS_CNT_LO || paddr == OFS_CAP_LO)) begin
      temp_nxt = snap_r;
    end
    if (rdSetup) begin
      unique case (paddr)
        OFS_CTRL_A: rd_nxt = ctrlA_r;
        OFS_CTRL_B: rd_nxt = ctrlB_r;
        OFS_CTRL_C: rd_nxt = {7'h00, capSrc_r};
        OFS_CNT_LO: begin rd_nxt = cnt_r[7:0]; snap_nxt = cnt_r[15:8]; end
        OFS_CNT_HI, OFS_CAP_HI: rd_nxt = temp_r;
        OFS_CMPA_LO: rd_nxt = cmpBuf[0][7:0];
        OFS_CMPA_HI: rd_nxt = cmpBuf[0][15:8];
        OFS_CMPB_LO: rd_nxt = cmpBuf[1][7:0];
        OFS_CMPB_HI: rd_nxt = cmpBuf[1][15:8];
        OFS_CAP_LO: begin rd_nxt = cap_r[7:0]; snap_nxt = cap_r[15:8]; end
        OFS_FLAGS: rd_nxt = {4'h0, flags_r};
        OFS_MASK: rd_nxt = {4'h0, mask_r};
        OFS_POWER: rd_nxt = {7'h00, timerPowerOff_r};
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlA_r <= CTRL_RST;
      ctrlB_r <= CTRL_RST;
      capSrc_r <= 1'b0;
      mask_r <= MASK_RST;
      flags_r <= FLAGS_RST;
      timerPowerOff_r <= POWER_RST;
      temp_r <= 8'h00;
      snap_r <= 8'h00;
      rd_r <= 8'h00;
      cnt_r <= WORD_RST;
      cap_r <= WORD_RST;
      dirDown_r <= 1'b0;
      presc_r <= 10'h000;
      extPrev_r <= 1'b0;
      samp_r <= '0;
      capLevel_r <= 1'b0;
    end else begin
      ctrlA_r <= ctrlA_nxt;
      ctrlB_r <= ctrlB_nxt;
      capSrc_r <= capSrc_nxt;
      mask_r <= mask_nxt;
      flags_r <= flags_nxt;
      timerPowerOff_r <= timerPowerOff_nxt;
      temp_r <= temp_nxt;
      snap_r <= snap_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      dirDown_r <= dirDown_nxt;
      presc_r <= presc_nxt;
      extPrev_r <= extCountPin;
      samp_r <= samp_nxt;
      capLevel_r <= capLevel_nxt;
    end
  end

endmodule

// ---- sixteen_bit_timer_core_chk.sv ----
module timer_core_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irqOverflow,
  input wire logic irqCompareA,
  input wire logic irqCompareB,
  input wire logic irqCapture
);
  import timer_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  sequence rdSetup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence maskOff;
    acc && pwrite && paddr == OFS_MASK && pwdata[3:0] == 4'h0;
  endsequence
  chk_ready_always: assert property (acc |-> pready)
    else $error("pready low in access");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data above bit 7");
  chk_force_zero: assert property (rdSetup(OFS_CTRL_C) |=> prdata[7:6] == 2'b00)
    else $error("force bits read back");
  chk_flag_upper: assert property (rdSetup(OFS_FLAGS) |=> prdata[7:4] == 4'h0)
    else $error("flag register upper bits set");
  chk_irq_a_flag: assert property (rdSetup(OFS_FLAGS) ##0 irqCompareA |=> prdata[FLAG_CMPA])
    else $error("compare A request without flag");
  chk_irq_cap_flag: assert property (rdSetup(OFS_FLAGS) ##0 irqCapture |=> prdata[FLAG_CAP])
    else $error("capture request without flag");
  chk_mask_gates: assert property (maskOff |=> !(irqOverflow || irqCompareA || irqCompareB || irqCapture))
    else $error("request while masked");
  chk_unmapped_err: assert property (acc && paddr > OFS_POWER |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_data_stands: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");
endmodule

// ---- sixteen_bit_timer_core_test.sv ----
module sixteen_bit_timer_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic extCountPin = 1'b0;
  logic capturePin = 1'b0;
  logic comparatorOut = 1'b0;
  logic [3:0] ackBus = 4'h0;
  logic [3:0] irq;
  logic [2:0] extDiv = 3'h0;
  logic outA;
  logic outAEn;
  logic outB;
  logic outBEn;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 48;
  int divTab [8] = '{0, 1, 8, 64, 256, 1024, 10, 10};
  logic [15:0] expQ [$];
  always #5 clock = ~clock;
  always @(posedge clock) begin
    extDiv <= (extDiv == 3'h4) ? 3'h0 : extDiv + 3'h1;
    if (extDiv == 3'h4) begin
      extCountPin <= ~extCountPin;
    end
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  cpu_bus_model cpu (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));
  sixteen_bit_timer_core dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extCountPin(extCountPin), .capturePin(capturePin), .comparatorOut(comparatorOut),
    .ackOverflow(ackBus[0]), .ackCompareA(ackBus[1]), .ackCompareB(ackBus[2]), .ackCapture(ackBus[3]),
    .irqOverflow(irq[0]), .irqCompareA(irq[1]), .irqCompareB(irq[2]), .irqCapture(irq[3]),
    .compareOutA(outA), .compareOutAEn(outAEn), .compareOutB(outB), .compareOutBEn(outBEn));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ack(input logic [3:0] m);
    @(posedge clock);
    ackBus <= m;
    @(posedge clock);
    ackBus <= 4'h0;
    // let the cleared flag settle before anyone samples the requests
    @(posedge clock);
  endtask
  task automatic flags_are(input logic [3:0] f);
    logic [7:0] b;
    cpu.rd(OFS_FLAGS, b);
    check({8'h00, b}, {12'h000, f});
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] b;
    logic [7:0] h;
    logic [15:0] v;
    logic [15:0] r;
    int e;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a <= 60; a += 4) begin
      cpu.rd(8'(a), b);
      check({8'h00, b}, 16'h0000);
    end
    cpu.power_up();
    repeat (4) begin
      v = 16'($random(seed));
      cpu.wr16(OFS_CNT_HI, v);
      expQ.push_back(v);
      repeat (20) @(posedge clock);
      cpu.rd16(OFS_CNT_LO, r);
      check(r, expQ.pop_front());
    end
    h = 8'($random(seed));
    cpu.wr(OFS_CNT_HI, h);
    cpu.wr(OFS_CNT_LO, 8'h11);
    cpu.wr(OFS_CMPB_LO, 8'h22);
    cpu.rd16(OFS_CNT_LO, r);
    check(r, {h, 8'h11});
    cpu.rd16(OFS_CMPB_LO, r);
    check(r, {h, 8'h22});
    cpu.wr16(OFS_CMPA_HI, {~h, 8'h33});
    cpu.rd16(OFS_CNT_LO, r);
    cpu.rd(OFS_CMPA_HI, b);
    check({8'h00, b}, {8'h00, ~h});
    // window of three ticks either side covers prescaler phase and external pin edge phase
    for (int cs = 1; cs < 8; cs++) begin
      cpu.wr16(OFS_CNT_HI, 16'h0000);
      cpu.wr(OFS_CTRL_B, 8'(cs));
      repeat (1100) @(posedge clock);
      cpu.wr(OFS_CTRL_B, {5'h00, CS_STOP});
      cpu.rd16(OFS_CNT_LO, v);
      e = 1103 / divTab[cs];
      check(16'(int'(v) >= e - 3 && int'(v) <= e + 3), 16'h0001);
      repeat (50) @(posedge clock);
      cpu.rd16(OFS_CNT_LO, r);
      check(r, v);
    end
    cpu.wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    cpu.wr16(OFS_CNT_HI, 16'h8000);
    cpu.wr(OFS_CTRL_B, 8'h00);
    cpu.rd16(OFS_CNT_LO, v);
    check(16'(v >= 16'h8000 && v <= 16'h8004), 16'h0001);
    cpu.wr16(OFS_CMPA_HI, 16'h0002);
    cpu.wr16(OFS_CMPB_HI, 16'h0003);
    cpu.wr16(OFS_CNT_HI, 16'hfffe);
    cpu.wr(OFS_FLAGS, 8'h0f);
    cpu.wr(OFS_MASK, 8'h0f);
    cpu.wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    repeat (10) @(posedge clock);
    cpu.wr(OFS_CTRL_B, 8'h00);
    flags_are(4'h7);
    check({12'h000, irq}, 16'h0007);
    ack(4'h1);
    flags_are(4'h6);
    cpu.wr(OFS_FLAGS, 8'h04);
    flags_are(4'h2);
    ack(4'h2);
    check({12'h000, irq}, 16'h0000);
    cpu.wr(OFS_MASK, 8'h00);
    cpu.wr(OFS_MASK, 8'h08);
    v = 16'($random(seed));
    cpu.wr16(OFS_CNT_HI, v);
    cpu.wr(OFS_CTRL_B, 8'h40);
    @(posedge clock);
    capturePin <= 1'b1;
    repeat (4) @(posedge clock);
    cpu.rd16(OFS_CAP_LO, r);
    check(r, v);
    flags_are(4'h8);
    check({12'h000, irq}, 16'h0008);
    ack(4'h8);
    flags_are(4'h0);
    cpu.wr16(OFS_CNT_HI, ~v);
    cpu.wr(OFS_CTRL_C, 8'h01);
    cpu.wr(OFS_CTRL_B, 8'hc0);
    @(posedge clock);
    comparatorOut <= 1'b1;
    repeat (2) @(posedge clock);
    comparatorOut <= 1'b0;
    repeat (10) @(posedge clock);
    cpu.rd16(OFS_CAP_LO, r);
    check(r, v);
    comparatorOut <= 1'b1;
    repeat (12) @(posedge clock);
    cpu.rd16(OFS_CAP_LO, r);
    check(r, ~v);
    cpu.wr(OFS_FLAGS, 8'h08);
    flags_are(4'h0);
    // fast pwm with 8-bit fixed top: wraps after 0x00ff
    cpu.wr16(OFS_CNT_HI, 16'h00fe);
    cpu.wr(OFS_CTRL_A, 8'h01);
    cpu.wr(OFS_CTRL_B, 8'h09);
    repeat (10) @(posedge clock);
    cpu.wr(OFS_CTRL_B, 8'h08);
    cpu.rd16(OFS_CNT_LO, v);
    check(v, 16'h000b);
    flags_are(4'h7);
    cpu.wr(OFS_FLAGS, 8'h0f);
    cpu.wr(OFS_CTRL_B, 8'h00);
    cpu.wr(OFS_CTRL_A, 8'h40);
    cpu.wr(OFS_CTRL_C, 8'h81);
    @(posedge clock);
    check({12'h000, outA, outAEn, outB, outBEn}, 16'h000c);
    wrap_up();
  end
endmodule
bind sixteen_bit_timer_core timer_core_chk chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irqOverflow(irqOverflow), .irqCompareA(irqCompareA), .irqCompareB(irqCompareB), .irqCapture(irqCapture));

// ---- timer_pkg.sv ----
package timer_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned N_UNITS = 2;

  // register byte addresses, one 32-bit word each, data in bits 7:0
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_CNT_LO = 8'h0c;
  localparam logic [7:0] OFS_CNT_HI = 8'h10;
  localparam logic [7:0] OFS_CMPA_LO = 8'h14;
  localparam logic [7:0] OFS_CMPA_HI = 8'h18;
  localparam logic [7:0] OFS_CMPB_LO = 8'h1c;
  localparam logic [7:0] OFS_CMPB_HI = 8'h20;
  localparam logic [7:0] OFS_CAP_LO = 8'h24;
  localparam logic [7:0] OFS_CAP_HI = 8'h28;
  localparam logic [7:0] OFS_FLAGS = 8'h2c;
  localparam logic [7:0] OFS_MASK = 8'h30;
  localparam logic [7:0] OFS_POWER = 8'h34;

  // control A fields
  localparam int unsigned WAVE_LO_LSB = 0;
  localparam int unsigned COM_B_LSB = 4;
  localparam int unsigned COM_A_LSB = 6;
  // control B fields
  localparam int unsigned CS_LSB = 0;
  localparam int unsigned WAVE_HI_LSB = 3;
  localparam int unsigned CAP_EDGE_BIT = 6;
  localparam int unsigned FILTER_EN_BIT = 7;
  // control C fields
  localparam int unsigned CAP_SRC_BIT = 0;
  localparam int unsigned FORCE_B_BIT = 6;
  localparam int unsigned FORCE_A_BIT = 7;
  // power register and flag/mask positions
  localparam int unsigned POWER_BIT = 0;
  localparam int unsigned FLAG_OVF = 0;
  localparam int unsigned FLAG_CMPA = 1;
  localparam int unsigned FLAG_CMPB = 2;
  localparam int unsigned FLAG_CAP = 3;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic POWER_RST = 1'b0;

  // counter landmarks
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // prescaler taps: tick when the low bits of the divider are all ones
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

  // capture noise filter: equal samples needed before a level is accepted
  localparam int unsigned FILTER_LEN = 4;

endpackage
